// ===== include/vimc_pkg.sv
package vimc_pkg;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] VIMC_A_CTRL   = 8'h00;
  localparam logic [7:0] VIMC_A_STATUS = 8'h04;
  localparam logic [7:0] VIMC_A_SUBMIT = 8'h08;
  localparam logic [7:0] VIMC_A_DEVMAP = 8'h0c;
  localparam logic [7:0] VIMC_A_VQUERY = 8'h10;
  localparam logic [7:0] VIMC_A_VINFO  = 8'h14;
  localparam logic [2:0] VIMC_A_CMD    = 3'h1;
  localparam int VIMC_CMD_WORDS = 8;

  localparam int VIMC_CTRL_SEI   = 0;
  localparam int VIMC_ST_BUSY    = 0;
  localparam int VIMC_ST_ERR     = 4;
  localparam int VIMC_ST_RDPTR   = 16;
  localparam int VIMC_DM_ID      = 0;
  localparam int VIMC_DM_SIZE    = 8;
  localparam int VIMC_DM_VALID   = 31;
  localparam int VIMC_VQ_SIZE    = 16;
  localparam int VIMC_VQ_VALID   = 31;

  // ----------------------------------------------------------------
  // Command packet fields (doubleword, lsb)
  // ----------------------------------------------------------------
  localparam logic [7:0] VIMC_OP_MAP_VCORE  = 8'h29;
  localparam logic [7:0] VIMC_OP_MAP_EVENT  = 8'h2a;
  localparam logic [7:0] VIMC_OP_MOVE_EVENT = 8'h21;
  localparam logic [7:0] VIMC_OP_MOVE_VCORE = 8'h22;
  localparam int VIMC_F_OP    = 0;
  localparam int VIMC_F_DEV   = 32;
  localparam int VIMC_F_EVENT = 0;
  localparam int VIMC_F_VCORE = 32;
  localparam int VIMC_F_VINT  = 0;
  localparam int VIMC_F_DBELL = 32;
  localparam int VIMC_F_VALID = 63;
  localparam int VIMC_F_DUPD  = 0;
  localparam int VIMC_F_RD    = 16;
  localparam int VIMC_F_VPT   = 16;
  localparam int VIMC_F_SIZE  = 0;
  localparam int VIMC_VPT_PAD = 16;
  localparam int VIMC_VCORE_W = 16;

  localparam logic [31:0] VIMC_LPI_MIN    = 32'h0000_2000;
  localparam logic [31:0] VIMC_DBELL_NONE = 32'h0000_03ff;
  localparam logic [15:0] VIMC_PKT_BYTES  = 16'h0020;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [3:0][63:0] vimc_pkt_type;

  typedef enum logic [3:0] {
    VIMC_E_OK, VIMC_E_UNSUP, VIMC_E_VCORE_OOR, VIMC_E_SIZE_OOR,
    VIMC_E_DEV_OOR, VIMC_E_DEV_UNMAP, VIMC_E_EVENT_OOR, VIMC_E_VINT_BAD,
    VIMC_E_DBELL_BAD, VIMC_E_ITE_UNMAP, VIMC_E_ITE_PHYS,
    VIMC_E_OLD_VCORE, VIMC_E_NEW_VCORE
  } vimc_err_type;

  typedef enum logic [1:0] {
    VIMC_RD_NONE, VIMC_RD_DISCARD, VIMC_RD_MOVE_PEND, VIMC_RD_RETARGET
  } vimc_rdkind_type;

  typedef struct packed {
    logic                    valid;
    logic [31:0]             rd;
    logic [51:0]             vpt;
    logic [4:0]              size;
  } vimc_vte_type;

  typedef struct packed {
    logic                    valid;
    logic [4:0]              size;
  } vimc_dte_type;

  typedef struct packed {
    logic                    valid;
    logic                    virt;
    logic [31:0]             vint;
    logic [31:0]             dbell;
    logic [VIMC_VCORE_W-1:0] vcore;
  } vimc_ite_type;

  typedef struct packed {
    vimc_rdkind_type         kind;
    logic [VIMC_VCORE_W-1:0] vcore;
    logic [31:0]             rd_old;
    logic [31:0]             rd_new;
    logic [51:0]             vpt_old;
    logic [51:0]             vpt_new;
    logic [31:0]             intid;
  } vimc_redist_type;

  typedef struct packed {
    logic                    cyc;
    logic                    stb;
    logic                    we;
    logic [7:0]              adr;
    logic [3:0]              sel;
    logic [31:0]             dat;
  } vimc_wb_type;

  typedef struct packed {
    logic                    valid;
    logic [31:0]             dev;
    logic [31:0]             event_num;
    logic                    scheduled;
  } vimc_xreq_type;

  typedef struct packed {
    logic                    hit;
    logic                    fire;
    logic [31:0]             rd;
    logic [31:0]             vint;
    logic [31:0]             dbell;
  } vimc_xans_type;

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  function automatic logic [7:0] vimc_op(vimc_pkt_type p);
    return p[0][VIMC_F_OP +: 8];
  endfunction

  function automatic logic [31:0] vimc_dev(vimc_pkt_type p);
    return p[0][VIMC_F_DEV +: 32];
  endfunction

  function automatic logic [31:0] vimc_event(vimc_pkt_type p);
    return p[1][VIMC_F_EVENT +: 32];
  endfunction

  function automatic logic [15:0] vimc_vcore(vimc_pkt_type p);
    return p[1][VIMC_F_VCORE +: VIMC_VCORE_W];
  endfunction

  function automatic logic [31:0] vimc_vint(vimc_pkt_type p);
    return p[2][VIMC_F_VINT +: 32];
  endfunction

  function automatic logic [31:0] vimc_dbell(vimc_pkt_type p);
    return p[2][VIMC_F_DBELL +: 32];
  endfunction

  function automatic logic [31:0] vimc_merge(logic [31:0] o, logic [31:0] n,
                                             logic [3:0] sel);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = n[b*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// ===== design/vimc_check.sv
`timescale 1ns/1ns
module vimc_check
  import vimc_pkg::*;
#(
  parameter int NUM_VCORE   = 8,
  parameter int NUM_DEV     = 4,
  parameter int EVENT_BITS  = 4,
  parameter int ID_BITS     = 16,
  parameter bit DIRECT_VIRT = 1'b1
) (
  // Command and table lookups
  input  wire vimc_pkt_type pkt_i,
  input  wire vimc_dte_type dte_i,
  input  wire vimc_ite_type ite_i,
  input  wire vimc_vte_type vte_new_i,
  input  wire vimc_vte_type vte_old_i,
  // Verdict
  output vimc_err_type      err_o
);

  function automatic logic lpi_ok(logic [31:0] x);
    return (x >= VIMC_LPI_MIN) && ((x >> ID_BITS) == 32'h0);
  endfunction

  function automatic logic dbell_ok(logic [31:0] x);
    return (x == VIMC_DBELL_NONE) || lpi_ok(x);
  endfunction

  logic [31:0] f_event;
  logic        dev_oor;
  logic        vc_oor;
  logic        ev_oor;

  assign f_event = vimc_event(pkt_i);
  assign dev_oor = vimc_dev(pkt_i) >= 32'(NUM_DEV);
  assign vc_oor  = 32'(vimc_vcore(pkt_i)) >= 32'(NUM_VCORE);
  assign ev_oor  = ((f_event >> ({1'b0, dte_i.size} + 6'h01)) != 32'h0) ||
                   ((f_event >> EVENT_BITS) != 32'h0);

  // Checks run in the order of their priority; the first failure names the error
  always_comb begin
    err_o = VIMC_E_OK;
    if (!DIRECT_VIRT) begin
      err_o = VIMC_E_UNSUP;                                       // [R21]
    end else begin
      case (vimc_op(pkt_i))
        VIMC_OP_MAP_VCORE: begin
          if (vc_oor) err_o = VIMC_E_VCORE_OOR;                   // [R5]
          else if (32'(pkt_i[3][VIMC_F_SIZE +: 5]) >= 32'(ID_BITS))
            err_o = VIMC_E_SIZE_OOR;                              // [R5]
        end
        VIMC_OP_MAP_EVENT: begin
          if (dev_oor) err_o = VIMC_E_DEV_OOR;                    // [R11]
          else if (vc_oor) err_o = VIMC_E_VCORE_OOR;              // [R11]
          else if (!dte_i.valid) err_o = VIMC_E_DEV_UNMAP;        // [R11]
          else if (ev_oor) err_o = VIMC_E_EVENT_OOR;              // [R11]
          else if (!lpi_ok(vimc_vint(pkt_i))) err_o = VIMC_E_VINT_BAD;     // [R9]
          else if (!dbell_ok(vimc_dbell(pkt_i))) err_o = VIMC_E_DBELL_BAD; // [R9]
        end
        VIMC_OP_MOVE_EVENT: begin
          if (dev_oor) err_o = VIMC_E_DEV_OOR;
          else if (vc_oor) err_o = VIMC_E_VCORE_OOR;
          else if (pkt_i[2][VIMC_F_DUPD] && !dbell_ok(vimc_dbell(pkt_i)))
            err_o = VIMC_E_DBELL_BAD;                             // [R15]
          else if (!dte_i.valid) err_o = VIMC_E_DEV_UNMAP;
          else if (ev_oor) err_o = VIMC_E_EVENT_OOR;
          else if (!ite_i.valid) err_o = VIMC_E_ITE_UNMAP;
          else if (!ite_i.virt) err_o = VIMC_E_ITE_PHYS;          // [R15]
          else if (!vte_old_i.valid) err_o = VIMC_E_OLD_VCORE;    // [R15]
          else if (!vte_new_i.valid) err_o = VIMC_E_NEW_VCORE;    // [R15]
        end
        VIMC_OP_MOVE_VCORE: begin
          if (vc_oor) err_o = VIMC_E_VCORE_OOR;
          else if (!vte_new_i.valid) err_o = VIMC_E_NEW_VCORE;
        end
        default: err_o = VIMC_E_UNSUP;
      endcase
    end
  end

endmodule

// ===== design/vimc_engine.sv
// Function
// [R1] Commands are 32-byte packets of four doublewords; fields located by doubleword.
// [R2] Map-core with valid clear unmaps the core and drops its interrupts.
// [R3] Pending table address holds bits 51:16; base gets sixteen zero bits.
// [R4] Size field is count of supported identifier bits minus one.
// [R5] Map-core errors: core id beyond maximum, or size beyond implemented bits.
// [R6] With error reporting enabled, each command error raises a coded system error.
// [R7] Map-event opcode 0x2a; device in dw0, core/event dw1, numbers dw2.
// [R8] Valid map-event writes a valid virtual entry: number, doorbell, core.
// [R9] Interrupt number needs at least 0x2000; doorbell is 1023 or that.
// [R10] Doorbell 1023 never fires a physical doorbell for unscheduled cores.
// [R11] Map-event errors: device, core, unmapped device, event, numbers.
// [R12] Software never maps an already mapped device/event pair.
// [R13] Move-event retargets the entry core and relocates pending state.
// [R14] Move-event updates the doorbell only when the update flag is set.
// [R15] Move-event errors: physical entry, unmapped cores, bad flagged doorbell.
// [R16] Move-event writes the entry before the pending state is moved.
// [R17] Software syncs the old core before moving an event again.
// [R18] Move-core overwrites the redistributor target of the core entry.
// [R19] Software supplies sequence tag and translator mask for multi-service moves.
// [R20] Software never moves a core scheduled on the target redistributor.
// [R21] These commands exist only with direct virtual injection built in.
// [R22] Each finished or skipped command advances the read pointer one packet.
//
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
module vimc_engine
  import vimc_pkg::*;
#(
  parameter int NUM_VCORE   = 8,
  parameter int NUM_DEV     = 4,
  parameter int EVENT_BITS  = 4,
  parameter int ID_BITS     = 16,
  parameter bit DIRECT_VIRT = 1'b1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Register bus
  input  wire vimc_wb_type  wb_i,
  output logic              wb_ack_o,
  output logic [31:0]       wb_dat_o,
  // Translation lookups
  input  wire vimc_xreq_type xreq_i,
  output vimc_xans_type     xans_o,
  // Redistributor effects
  output vimc_redist_type   redist_o,
  // System error report
  output logic              sys_err_o,
  output vimc_err_type      sys_err_code_o
);

  localparam int VC_W = $clog2(NUM_VCORE);
  localparam int DV_W = $clog2(NUM_DEV);
  localparam int IT_N = NUM_DEV << EVENT_BITS;
  localparam int IT_W = DV_W + EVENT_BITS;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (NUM_VCORE < 2 || NUM_VCORE > 65536 || (NUM_VCORE & (NUM_VCORE - 1)) != 0)
    $error("NUM_VCORE must be a power of two from 2 to 65536");
  if (NUM_DEV < 2 || NUM_DEV > 256 || (NUM_DEV & (NUM_DEV - 1)) != 0)
    $error("NUM_DEV must be a power of two from 2 to 256");
  if (EVENT_BITS < 1 || EVENT_BITS > 12)
    $error("EVENT_BITS must lie from 1 to 12");
  if (ID_BITS < 14 || ID_BITS > 31)
    $error("ID_BITS must lie from 14 to 31");

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_MOVE, ST_DONE} vimc_fsm_type;

  typedef struct packed {
    vimc_fsm_type                    fsm;
    logic                            sei;
    logic                            ack;
    logic [31:0]                     rdata;
    logic [VIMC_CMD_WORDS-1:0][31:0] cmd;
    logic [15:0]                     rd_ptr;
    vimc_err_type                    err;
    logic [VC_W-1:0]                 qidx;
    vimc_redist_type                 move;
    vimc_redist_type                 redist;
    logic                            sys_err;
    vimc_err_type                    sys_code;
    vimc_xans_type                   xans;
    vimc_dte_type [NUM_DEV-1:0]      dte;
    vimc_vte_type [NUM_VCORE-1:0]    vte;
    vimc_ite_type [IT_N-1:0]         ite;
  } vimc_state_type;

  vimc_state_type s_r;
  vimc_state_type s_nxt;

  // ----------------------------------------------------------------
  // Command decode and table lookups
  // ----------------------------------------------------------------
  vimc_pkt_type  pkt;
  logic [7:0]    f_op;
  logic [31:0]   f_dev;
  logic [31:0]   f_event;
  logic [15:0]   f_vcore;
  logic [31:0]   f_vint;
  logic [31:0]   f_dbell;
  logic [31:0]   f_rd;
  logic [35:0]   f_vpt;
  logic [4:0]    f_size;
  logic          f_valid;
  logic          f_dupd;
  logic [VC_W-1:0] vc_new;
  logic [IT_W-1:0] ite_idx;
  vimc_dte_type  dte_cur;
  vimc_ite_type  ite_cur;
  vimc_vte_type  vte_new;
  vimc_vte_type  vte_old;
  vimc_err_type  chk_err;

  assign pkt     = vimc_pkt_type'(s_r.cmd);                       // [R1]
  assign f_op    = vimc_op(pkt);                                  // [R7]
  assign f_dev   = vimc_dev(pkt);
  assign f_event = vimc_event(pkt);
  assign f_vcore = vimc_vcore(pkt);
  assign f_vint  = vimc_vint(pkt);
  assign f_dbell = vimc_dbell(pkt);
  assign f_rd    = pkt[2][VIMC_F_RD +: 32];
  assign f_vpt   = pkt[3][VIMC_F_VPT +: 36];                      // [R3]
  assign f_size  = pkt[3][VIMC_F_SIZE +: 5];
  assign f_valid = pkt[2][VIMC_F_VALID];
  assign f_dupd  = pkt[2][VIMC_F_DUPD];
  assign vc_new  = f_vcore[VC_W-1:0];
  assign ite_idx = {f_dev[DV_W-1:0], f_event[EVENT_BITS-1:0]};
  assign dte_cur = s_r.dte[f_dev[DV_W-1:0]];
  assign ite_cur = s_r.ite[ite_idx];
  assign vte_new = s_r.vte[vc_new];
  assign vte_old = s_r.vte[ite_cur.vcore[VC_W-1:0]];

  vimc_check #(
    .NUM_VCORE   (NUM_VCORE),
    .NUM_DEV     (NUM_DEV),
    .EVENT_BITS  (EVENT_BITS),
    .ID_BITS     (ID_BITS),
    .DIRECT_VIRT (DIRECT_VIRT)
  ) u_check (
    .pkt_i     (pkt),
    .dte_i     (dte_cur),
    .ite_i     (ite_cur),
    .vte_new_i (vte_new),
    .vte_old_i (vte_old),
    .err_o     (chk_err)
  );

  // ----------------------------------------------------------------
  // Translation lookup
  // ----------------------------------------------------------------
  logic [DV_W-1:0] x_dev;
  vimc_ite_type    x_ent;
  vimc_vte_type    x_vte;
  logic            x_in;

  assign x_dev = xreq_i.dev[DV_W-1:0];
  assign x_ent = s_r.ite[{x_dev, xreq_i.event_num[EVENT_BITS-1:0]}];
  assign x_vte = s_r.vte[x_ent.vcore[VC_W-1:0]];
  assign x_in  = (xreq_i.dev < 32'(NUM_DEV)) && s_r.dte[x_dev].valid &&
                 ((xreq_i.event_num >> EVENT_BITS) == 32'h0);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic bus_hit;
  assign bus_hit = wb_i.cyc && wb_i.stb && !s_r.ack;

  always_comb begin
    vimc_redist_type ev;
    ev = '0;
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.sys_err = 1'b0;
    s_nxt.redist.kind = VIMC_RD_NONE;

    // Register bus: one wait state, every address answered
    if (bus_hit) begin
      s_nxt.ack = 1'b1;
      s_nxt.rdata = 32'h0;
      if (wb_i.we) begin
        if (wb_i.adr[7:5] == VIMC_A_CMD) begin
          // Packet words are frozen while a command runs
          if (s_r.fsm == ST_IDLE) begin
            s_nxt.cmd[wb_i.adr[4:2]] =
              vimc_merge(s_r.cmd[wb_i.adr[4:2]], wb_i.dat, wb_i.sel);   // [R1]
          end
        end else begin
          case (wb_i.adr)
            VIMC_A_CTRL: begin
              if (wb_i.sel[0]) s_nxt.sei = wb_i.dat[VIMC_CTRL_SEI];
            end
            VIMC_A_SUBMIT: begin
              if (s_r.fsm == ST_IDLE) s_nxt.fsm = ST_EXEC;
            end
            VIMC_A_DEVMAP: begin
              if ({1'b0, wb_i.dat[VIMC_DM_ID +: 8]} < 9'(NUM_DEV)) begin
                s_nxt.dte[wb_i.dat[VIMC_DM_ID +: DV_W]] =
                  '{valid: wb_i.dat[VIMC_DM_VALID], size: wb_i.dat[VIMC_DM_SIZE +: 5]};
              end
            end
            VIMC_A_VQUERY: s_nxt.qidx = wb_i.dat[VC_W-1:0];
            default: ;
          endcase
        end
      end else begin
        if (wb_i.adr[7:5] == VIMC_A_CMD) begin
          s_nxt.rdata = s_r.cmd[wb_i.adr[4:2]];
        end else begin
          case (wb_i.adr)
            VIMC_A_CTRL: s_nxt.rdata[VIMC_CTRL_SEI] = s_r.sei;
            VIMC_A_STATUS: begin
              s_nxt.rdata[VIMC_ST_BUSY] = (s_r.fsm != ST_IDLE);
              s_nxt.rdata[VIMC_ST_ERR +: 4] = s_r.err;
              s_nxt.rdata[VIMC_ST_RDPTR +: 16] = s_r.rd_ptr;
            end
            VIMC_A_VQUERY: begin
              s_nxt.rdata[VC_W-1:0] = s_r.qidx;
              s_nxt.rdata[VIMC_VQ_SIZE +: 5] = s_r.vte[s_r.qidx].size;
              s_nxt.rdata[VIMC_VQ_VALID] = s_r.vte[s_r.qidx].valid;
            end
            VIMC_A_VINFO: s_nxt.rdata = s_r.vte[s_r.qidx].rd;
            default: ;
          endcase
        end
      end
    end

    // Command engine
    unique case (s_r.fsm)
      ST_IDLE: ;
      ST_EXEC: begin
        s_nxt.err = chk_err;
        s_nxt.fsm = ST_DONE;
        if (chk_err != VIMC_E_OK) begin
          // Tables untouched; the packet is skipped
          s_nxt.sys_err = s_r.sei;                                // [R6]
          s_nxt.sys_code = chk_err;                               // [R6]
        end else begin
          unique case (f_op)
            VIMC_OP_MAP_VCORE: begin
              s_nxt.vte[vc_new] = '{valid: f_valid, rd: f_rd,
                                    vpt: {f_vpt, {VIMC_VPT_PAD{1'b0}}},   // [R3]
                                    size: f_size};                        // [R4]
              if (!f_valid) begin
                for (int i = 0; i < IT_N; i++) begin
                  if (s_r.ite[i].valid && s_r.ite[i].virt &&
                      s_r.ite[i].vcore == f_vcore) begin
                    s_nxt.ite[i].valid = 1'b0;                    // [R2]
                  end
                end
                ev.kind = VIMC_RD_DISCARD;                        // [R2]
                ev.vcore = f_vcore;
                ev.rd_old = vte_new.rd;
                ev.vpt_old = vte_new.vpt;
                s_nxt.redist = ev;
              end
            end
            VIMC_OP_MAP_EVENT: begin
              // An existing entry is overwritten without a check [R12]
              s_nxt.ite[ite_idx] = '{valid: 1'b1, virt: 1'b1, vint: f_vint,
                                     dbell: f_dbell, vcore: f_vcore};     // [R8]
            end
            VIMC_OP_MOVE_EVENT: begin
              s_nxt.ite[ite_idx].vcore = f_vcore;                 // [R13]
              if (f_dupd) begin
                s_nxt.ite[ite_idx].dbell = f_dbell;               // [R14]
              end
              ev.kind = VIMC_RD_MOVE_PEND;
              ev.vcore = f_vcore;
              ev.rd_old = vte_old.rd;
              ev.rd_new = vte_new.rd;
              ev.vpt_old = vte_old.vpt;
              ev.vpt_new = vte_new.vpt;
              ev.intid = ite_cur.vint;
              s_nxt.move = ev;
              // Entry is written this cycle, pending state moves next
              s_nxt.fsm = ST_MOVE;                                // [R16]
            end
            VIMC_OP_MOVE_VCORE: begin
              s_nxt.vte[vc_new].rd = f_rd;                        // [R18]
              ev.kind = VIMC_RD_RETARGET;
              ev.vcore = f_vcore;
              ev.rd_old = vte_new.rd;
              ev.rd_new = f_rd;
              ev.vpt_new = vte_new.vpt;
              s_nxt.redist = ev;
            end
            default: ;
          endcase
        end
      end
      ST_MOVE: begin
        s_nxt.redist = s_r.move;                                  // [R13] [R16]
        s_nxt.fsm = ST_DONE;
      end
      ST_DONE: begin
        s_nxt.rd_ptr = s_r.rd_ptr + VIMC_PKT_BYTES;               // [R22]
        s_nxt.fsm = ST_IDLE;
      end
    endcase

    // Translation answer, one cycle after the request
    s_nxt.xans.hit = xreq_i.valid && x_in && x_ent.valid && x_ent.virt &&
                     x_vte.valid;
    s_nxt.xans.rd = x_vte.rd;
    s_nxt.xans.vint = x_ent.vint;
    s_nxt.xans.dbell = x_ent.dbell;
    // Doorbell only for a core that is not running, and never for the null id
    s_nxt.xans.fire = s_nxt.xans.hit && !xreq_i.scheduled &&
                      (x_ent.dbell != VIMC_DBELL_NONE);            // [R10]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o       = s_r.ack;
  assign wb_dat_o       = s_r.rdata;
  assign xans_o         = s_r.xans;
  assign redist_o       = s_r.redist;
  assign sys_err_o      = s_r.sys_err;
  assign sys_err_code_o = s_r.sys_code;

endmodule

// ===== sim/vimc_engine_chk.sv
`timescale 1ns/1ns
module vimc_engine_chk
  import vimc_pkg::*;
(
  input wire logic            clk_i,
  input wire logic            rst_i,
  input wire vimc_wb_type     wb_i,
  input wire logic            wb_ack_o,
  input wire vimc_xreq_type   xreq_i,
  input wire vimc_xans_type   xans_o,
  input wire vimc_redist_type redist_o,
  input wire logic            sys_err_o,
  input wire vimc_err_type    sys_err_code_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
  property p_err; sys_err_o |-> sys_err_code_o != VIMC_E_OK ##1 !sys_err_o; endproperty
  a_err: assert property (p_err) else $error("error pulse");
  property p_fire; xans_o.fire |-> xans_o.hit && xans_o.dbell != VIMC_DBELL_NONE; endproperty
  a_fire: assert property (p_fire) else $error("doorbell fire");
  property p_sched; xreq_i.valid && xreq_i.scheduled |=> !xans_o.fire; endproperty
  a_sched: assert property (p_sched) else $error("fire while scheduled");
  property p_vint; xans_o.hit |-> xans_o.vint >= VIMC_LPI_MIN; endproperty
  a_vint: assert property (p_vint) else $error("bad number hit");
  property p_noreq; !xreq_i.valid |=> !xans_o.hit; endproperty
  a_noreq: assert property (p_noreq) else $error("hit without lookup");
  property p_pad; redist_o.kind == VIMC_RD_MOVE_PEND |-> redist_o.vpt_new[15:0] == 16'h0; endproperty
  a_pad: assert property (p_pad) else $error("table base not aligned");
  property p_kind; redist_o.kind != VIMC_RD_NONE |=> redist_o.kind == VIMC_RD_NONE; endproperty
  a_kind: assert property (p_kind) else $error("event too long");
endmodule

bind vimc_engine vimc_engine_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
  .wb_ack_o(wb_ack_o), .xreq_i(xreq_i), .xans_o(xans_o), .redist_o(redist_o),
  .sys_err_o(sys_err_o), .sys_err_code_o(sys_err_code_o));

// ===== sim/vimc_far.sv
`timescale 1ns/1ns
module vimc_far
  import vimc_pkg::*;
(
  input  wire logic            clk_i,
  input  wire vimc_redist_type redist_i,
  output vimc_redist_type      last_o
);
  // Keeps only the latest event; the bench inspects it after the move-event and the unmapping map-core commands
  initial last_o = '0;
  always @(posedge clk_i) begin
    if (redist_i.kind != VIMC_RD_NONE) begin
      last_o <= redist_i;
    end
  end
endmodule

// ===== sim/vimc_engine_tb.sv
`timescale 1ns/1ns
module vimc_engine_tb
  import vimc_pkg::*;
;
  logic clk_i, rst_i, ack, sys_err;
  logic [31:0] dat, q;
  vimc_wb_type wb;
  vimc_xreq_type xreq;
  vimc_xans_type xans;
  vimc_redist_type rdev, last;
  vimc_err_type code;
  int n_errors = 0, samples_checked = 0, n_cmd = 0, cycles = 0, n_pulse = 0;
  vimc_engine dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_ack_o(ack), .wb_dat_o(dat),
    .xreq_i(xreq), .xans_o(xans), .redist_o(rdev), .sys_err_o(sys_err), .sys_err_code_o(code));
  vimc_far far (.clk_i(clk_i), .redist_i(rdev), .last_o(last));
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", s, e, g);
      n_errors++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    wb <= '{1'b1, 1'b1, w, a, 4'hf, d};
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) n_errors++;
    r = dat;
    wb <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  // Waits on busy, so a second submit never lands mid-command
  task automatic cmd(input logic [63:0] d0, d1, d2, d3, input vimc_err_type c);
    logic [63:0] p [4];
    p = '{d0, d1, d2, d3};
    for (int k = 0; k < 8; k++) wr(8'h20 + 8'(4 * k), k[0] ? p[k/2][63:32] : p[k/2][31:0]);
    wr(VIMC_A_SUBMIT, 32'h0);
    n_cmd++;
    for (int k = 0; k < 20; k++) begin
      bus(1'b0, VIMC_A_STATUS, 32'h0, q);
      if (q[0] === 1'b0) break;
    end
    chk("code", 32'(c), 32'(q[7:4]));
    chk("rdptr", 32'(n_cmd * 32), 32'(q[31:16]));
  endtask
  task automatic look(input logic [31:0] ev, input logic sc = 1'b0);
    @(posedge clk_i);
    xreq <= '{1'b1, 32'h1, ev, sc};
    @(posedge clk_i);
    xreq <= '0;
    #1;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (sys_err === 1'b1) n_pulse <= n_pulse + 1;
    if (cycles == 5000) begin
      n_errors++;
      close_out;
    end
  end
  initial begin
    rst_i = 1'b1;
    wb = '0;
    xreq = '0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(VIMC_A_CTRL, 32'h1);
    wr(VIMC_A_DEVMAP, 32'h8000_0301);
    cmd(64'h29, 64'h1_0000_0000, 64'h8000_0000_0011_0000, 64'h5_0003, VIMC_E_OK);
    cmd(64'h29, 64'h2_0000_0000, 64'h8000_0000_0022_0000, 64'h5_0003, VIMC_E_OK);
    cmd(64'h29, 64'h8_0000_0000, 64'h0, 64'h5_0003, VIMC_E_VCORE_OOR);
    cmd(64'h1_0000_002a, 64'h1_0000_0002, 64'h3ff_0000_2005, 64'h0, VIMC_E_OK);
    look(32'h2);
    chk("hit", 32'h1, 32'(xans.hit));
    chk("vint", 32'h2005, xans.vint);
    chk("fire", 32'h0, 32'(xans.fire));
    cmd(64'h1_0000_002a, 64'h1_0000_0003, 64'h3ff_0000_1000, 64'h0, VIMC_E_VINT_BAD);
    chk("syscode", 32'(VIMC_E_VINT_BAD), 32'(code));
    cmd(64'h1_0000_0021, 64'h5_0000_0002, 64'h0, 64'h0, VIMC_E_NEW_VCORE);
    cmd(64'h1_0000_0021, 64'h2_0000_0002, 64'h2100_0000_0000, 64'h0, VIMC_E_OK);
    look(32'h2);
    chk("rd", 32'h22, xans.rd);
    chk("dbell", 32'h3ff, xans.dbell);
    chk("kind", 32'(VIMC_RD_MOVE_PEND), 32'(last.kind));
    chk("vpt", 32'h5_0000, last.vpt_new[31:0]);
    cmd(64'h22, 64'h2_0000_0000, 64'h33_0000, 64'h0, VIMC_E_OK);
    wr(VIMC_A_VQUERY, 32'h2);
    bus(1'b0, VIMC_A_VINFO, 32'h0, q);
    chk("vinfo", 32'h33, q);
    cmd(64'h1_0000_002a, 64'h1_0000_0004, 64'h2001_0000_2006, 64'h0, VIMC_E_OK);
    look(32'h4);
    chk("bell", 32'h1, 32'(xans.fire));
    look(32'h4, 1'b1);
    chk("sched", 32'h0, 32'(xans.fire));
    cmd(64'h1_0000_0021, 64'h2_0000_0004, 64'h3ff_0000_0001, 64'h0, VIMC_E_OK);
    look(32'h4);
    chk("newbell", 32'h3ff, xans.dbell);
    chk("newrd", 32'h33, xans.rd);
    cmd(64'h29, 64'h2_0000_0000, 64'h0, 64'h5_0003, VIMC_E_OK);
    look(32'h2);
    chk("unmap", 32'h0, 32'(xans.hit));
    chk("drop", 32'(VIMC_RD_DISCARD), 32'(last.kind));
    chk("pulses", 32'h3, 32'(n_pulse));
    close_out;
  end
endmodule
